// file: hw/osw_regs.svh
// Constants for the octal switch serial control block.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef OSW_REGS_SVH
`define OSW_REGS_SVH
`define OSW_WORD_W        16
`define OSW_CMD_OUT_LSB   0
`define OSW_CMD_SENSE_LSB 8
`define OSW_STAT_CH_LSB   0
`define OSW_CMD_RESET     16'h0000
`define OSW_STAT_RESET    16'h0000
`define OSW_FRAME_MIN     16
`define OSW_FRAME_STEP    8
`define OSW_CLK_MHZ       100
`define OSW_FILT_MIN_US   100
`define OSW_FILT_MAX_US   300
// Least filter time rounded up to whole cycles
`define OSW_FILT_CYC      (`OSW_FILT_MIN_US * `OSW_CLK_MHZ)
`endif

// file: hw/osw_pkg.sv
// Types for the octal switch serial control block.
// Assumes osw_regs.svh is on the include path.
package osw_pkg;
   typedef logic [15:0] osw_word_t;
   typedef logic [7:0]  osw_chan_t;
endpackage

// file: hw/osw_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to core_clk.
module osw_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else if (clk_en)
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

// file: hw/osw_filter.sv
// Open-load filter timer, restarted on each chip-select rise.
// Assumes restart is a one-cycle pulse in the core domain.
`include "osw_regs.svh"
module osw_filter #(
   parameter int FILT_CYC = `OSW_FILT_CYC
) (
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic clk_en,
   input  wire logic sleep,
   input  wire logic restart,
   output logic      expired
);
   logic [31:0] cnt_ff;
   logic        done_ff;
   wire         at_end = (cnt_ff == 32'(FILT_CYC - 1));

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (sleep || restart)
         begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
         end
         else if (!done_ff)
         begin
            cnt_ff  <= cnt_ff + 32'd1;
            done_ff <= at_end;
         end
      end
   end

   assign expired = done_ff;
endmodule

// file: hw/osw_top.sv
// Serial control and fault reporting for an eight-channel load switch.
// Assumes the host is the serial master; pins are asynchronous and
// sampled by core_clk, whose rate must far exceed the serial clock.
//
// Summary of operation
// - Each frame moves a 16-bit command in and 16-bit status out, MSB first.
// - Received command takes effect only at chip-select rising edge.
// - Command bits 7..0 switch channels eight..one; one means on.
// - Command bits 15..8 enable sense current of channels eight..one.
// - Status bits 15..8 always read zero.
// - Status bits 7..0 flag any short, open load or thermal fault.
// - Open load on a channel whose command bit is on is not flagged.
// - Off-state open load flagged only with sense current enabled.
// - Over-voltage forces all switches off; command kept and restored.
// - Thermal fault turns off only its channel and flags it; resumes after.
// - Sleep clears all control registers: switches off, sense disabled.
// - Wake pin low or logic supply lost means sleep; sense sources off.
// - Status shifts out while the command shifts in, full duplex.
// - 32-bit frame returns status then echo; last 16 bits become command.
// - Accept frames of 16 to 56 clocks in steps of 8; else ignore.
// - Chip-select rise restarts open-load filter; comparator read after it.
// - Detected open load stays latched until the host reads it or sleep clears it.
// - Off-state open load uses per-channel comparator, counts when bit one.
// - Thermal short cycles retry automatically; shorts reported always.
// - Input sampled on falling serial clock, output changes on rising.
// - With chip select high, clock and data ignored, output released.
// - Direct-drive inputs five and six are ORed with their command bits.
`include "osw_regs.svh"
module osw_top #(
   parameter int FILT_CYC = `OSW_FILT_CYC
) (
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   input  wire logic                 clk_en,
   input  wire logic                 chip_select_n,
   input  wire logic                 serial_clock,
   input  wire logic                 serial_input_pin,
   output logic                      serial_output,
   output logic                      serial_output_oe_n,
   input  wire logic                 device_wake,
   input  wire logic                 logic_supply_ok,
   input  wire logic                 direct_drive_five,
   input  wire logic                 direct_drive_six,
   input  wire logic                 supply_overvoltage_level,
   input  wire osw_pkg::osw_chan_t   thermal_shutdown,
   input  wire osw_pkg::osw_chan_t   short_detect,
   input  wire osw_pkg::osw_chan_t   open_load_threshold,
   output osw_pkg::osw_chan_t        switch_on,
   output osw_pkg::osw_chan_t        sense_enable
);
   localparam int NS = 16;

   // All pin inputs pass two flops before any logic reads them.
   // Select goes through inverted so the synchroniser resets to idle,
   // avoiding a false select edge right after reset.
   logic [NS-1:0] pins_raw;
   logic [NS-1:0] pins_s;
   assign pins_raw = {~chip_select_n, serial_clock, serial_input_pin,
                      device_wake, logic_supply_ok, direct_drive_five,
                      direct_drive_six, supply_overvoltage_level,
                      open_load_threshold};

   osw_sync #(.W(NS)) u_sync (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   osw_pkg::osw_chan_t therm_s;
   osw_pkg::osw_chan_t short_s;
   osw_sync #(.W(16)) u_sync_flt (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .async_in ({thermal_shutdown, short_detect}),
      .sync_out ({therm_s, short_s})
   );

   wire                cs_n_s  = !pins_s[15];
   wire                sclk_s  = pins_s[14];
   wire                sdi_s   = pins_s[13];
   wire                wake_s  = pins_s[12];
   wire                vok_s   = pins_s[11];
   wire                dd5_s   = pins_s[10];
   wire                dd6_s   = pins_s[9];
   wire                ov_s    = pins_s[8];
   wire osw_pkg::osw_chan_t olc_s = pins_s[7:0];
   osw_pkg::osw_chan_t ol_cmp;
   assign ol_cmp = olc_s;

   // Sleep when wake pin low or logic supply gone
   wire sleep = !wake_s || !vok_s;

   logic               cs_n_d_ff;
   logic               sclk_d_ff;
   logic [15:0]        shift_ff;
   logic [5:0]         cnt_ff;
   logic               cnt_ovf_ff;
   logic               sdo_ff;
   logic               oe_n_ff;
   osw_pkg::osw_word_t cmd_ff;
   osw_pkg::osw_chan_t ol_lat_ff;
   osw_pkg::osw_chan_t sw_ff;
   osw_pkg::osw_chan_t sen_ff;

   wire cs_fall  = cs_n_d_ff && !cs_n_s;
   wire cs_rise  = !cs_n_d_ff && cs_n_s;
   wire selected = !cs_n_s && !cs_n_d_ff;
   wire sclk_r   = selected && sclk_s && !sclk_d_ff;
   wire sclk_f   = selected && !sclk_s && sclk_d_ff;

   // Frame accepted for 16 + n*8 falling edges, up to 56
   wire frame_ok = !cnt_ovf_ff && (cnt_ff >= 6'(`OSW_FRAME_MIN)) &&
                   (cnt_ff[2:0] == 3'd0);

   wire filt_done;
   osw_filter #(.FILT_CYC(FILT_CYC)) u_filt (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .sleep    (sleep),
      .restart  (cs_rise),
      .expired  (filt_done)
   );

   wire [7:0] cmd_out   = cmd_ff[`OSW_CMD_OUT_LSB +: 8];
   wire [7:0] cmd_sense = cmd_ff[`OSW_CMD_SENSE_LSB +: 8];
   // Open load counts only command off, sense on, after filter
   wire [7:0] ol_now = ol_cmp & ~cmd_out & cmd_sense &
                       {8{filt_done}};
   // Shorts and thermal reported regardless of sense enables
   wire [7:0] fault_now = short_s | therm_s | ol_lat_ff;
   wire [15:0] status_word = {8'h00, fault_now};

   // Direct drives ORed onto channels five and six
   wire [7:0] drive_req = cmd_out |
                          {2'b00, dd6_s, dd5_s, 4'h0};
   // Thermal drops only its channel; overvoltage drops all
   wire [7:0] nxt_sw = sleep ? 8'h00 :
                       (drive_req & ~therm_s & {8{!ov_s}});
   wire [7:0] nxt_sen = sleep ? 8'h00 : cmd_sense;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cs_n_d_ff <= 1'b1;
         sclk_d_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         cs_n_d_ff <= cs_n_s;
         sclk_d_ff <= sclk_s;
      end
   end

   // Shift path: in on falling clock, out on rising clock, MSB first
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         shift_ff   <= `OSW_STAT_RESET;
         cnt_ff     <= '0;
         cnt_ovf_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (cs_fall)
         begin
            shift_ff   <= status_word;
            cnt_ff     <= '0;
            cnt_ovf_ff <= 1'b0;
         end
         else if (sclk_f)
         begin
            // Status and command share one register, so a 32-clock
            // frame echoes the host's first word
            shift_ff   <= {shift_ff[14:0], sdi_s};
            cnt_ff     <= cnt_ff + 6'd1;
            if (cnt_ff == 6'h3f)
               cnt_ovf_ff <= 1'b1;
         end
      end
   end

   // Output pin: first bit valid at select, advanced on rising clock
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sdo_ff  <= 1'b0;
         oe_n_ff <= 1'b1;
      end
      else if (clk_en)
      begin
         oe_n_ff <= cs_n_s || sleep;
         if (cs_fall)
            sdo_ff <= status_word[15];
         else if (sclk_r)
            sdo_ff <= shift_ff[14];
      end
   end

   // Command register, open-load latch and driver outputs
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cmd_ff    <= `OSW_CMD_RESET;
         ol_lat_ff <= '0;
         sw_ff     <= '0;
         sen_ff    <= '0;
      end
      else if (clk_en)
      begin
         if (sleep)
         begin
            cmd_ff    <= `OSW_CMD_RESET;
            ol_lat_ff <= '0;
         end
         else
         begin
            if (cs_rise && frame_ok)
               cmd_ff <= shift_ff;
            // New detections win over the read-clear
            ol_lat_ff <= (cs_fall ? 8'h00 : ol_lat_ff) | ol_now;
         end
         sw_ff  <= nxt_sw;
         sen_ff <= nxt_sen;
      end
   end

   assign serial_output      = sdo_ff;
   assign serial_output_oe_n = oe_n_ff;
   assign switch_on          = sw_ff;
   assign sense_enable       = sen_ff;
endmodule

// file: test/osw_asserts.sv
// Pin-level checker for the switch block.
// Assumes binding to osw_top; inputs settle within six core cycles.
module osw_asserts (
   input wire logic               core_clk,
   input wire logic               nrst,
   input wire logic               chip_select_n,
   input wire logic               serial_output_oe_n,
   input wire logic               device_wake,
   input wire logic               logic_supply_ok,
   input wire logic               direct_drive_five,
   input wire logic               supply_overvoltage_level,
   input wire osw_pkg::osw_chan_t thermal_shutdown,
   input wire osw_pkg::osw_chan_t switch_on,
   input wire osw_pkg::osw_chan_t sense_enable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   AST_OV_OFF: assert property (
      supply_overvoltage_level [*6] |-> switch_on == 8'h00)
      else $error("switch on during overvoltage");
   AST_SLEEP_CLR: assert property (
      !device_wake [*6] |-> switch_on == 8'h00 && sense_enable == 8'h00)
      else $error("control not cleared in sleep");
   AST_SUPPLY_OFF: assert property (
      !logic_supply_ok [*6] |-> sense_enable == 8'h00)
      else $error("sense current on without supply");
   AST_DESEL_REL: assert property (
      chip_select_n [*6] |-> serial_output_oe_n)
      else $error("output driven while deselected");
   AST_HOLD: assert property (
      (!chip_select_n && device_wake && logic_supply_ok) [*8]
      |-> $stable(sense_enable))
      else $error("sense changed inside a frame");
   AST_THERM: assert property (
      $stable(thermal_shutdown) [*6]
      |-> (switch_on & thermal_shutdown) == 8'h00)
      else $error("overheated channel still on");
   AST_DIRECT: assert property (
      (direct_drive_five && device_wake && logic_supply_ok &&
       !supply_overvoltage_level && !thermal_shutdown[4]) [*6]
      |-> switch_on[4])
      else $error("direct drive five ignored");
   AST_LATE_REL: assert property (
      !serial_output_oe_n && chip_select_n |-> !$past(chip_select_n, 5))
      else $error("output held after deselect");
endmodule
bind osw_top osw_asserts i_chk (.core_clk, .nrst, .chip_select_n,
   .serial_output_oe_n, .device_wake, .logic_supply_ok,
   .direct_drive_five, .supply_overvoltage_level, .thermal_shutdown,
   .switch_on, .sense_enable);

// file: test/osw_host.sv
// Host serial master model driving the switch block's pins.
// Assumes a 160 ns serial clock that stands low between frames.
module osw_host (
   input wire logic sdo,
   output logic     cs_n,
   output logic     sclk,
   output logic     sdi
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cs_n, sclk, sdi} = 3'b100;
   task automatic xfer(input logic [31:0] tx, input int n,
                       output logic [31:0] rx);
      rx = '0;
      cs_n = 1'b0;
      #80;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi = tx[i];
         rx = {rx[30:0], sdo};
         #40 sclk = 1'b1;
         #80 sclk = 1'b0;
         #40;
      end
      cs_n = 1'b1;
      sdi = ~sdi;
      // Gap scaled to the shortened filter time
      #400;
   endtask
endmodule

// file: test/octal_switch_spi_fault_ctrl_bench.sv
// Self-checking bench for the switch block against a behavioural model.
// Assumes osw_top, osw_host and the checker are compiled first.
module octal_switch_spi_fault_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FILT = 20;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic wake = 1'b1;
   logic sup = 1'b1;
   logic dd5 = 1'b0;
   logic dd6 = 1'b0;
   logic ov = 1'b0;
   logic cs_n, sclk, sdi, sdo, oe_n;
   osw_pkg::osw_chan_t therm = '0, shrt = '0, olt = '0, sw, sen;
   osw_pkg::osw_chan_t ol_lat = '0;
   int cmd = 0, fail_count = 0, checks_done = 0;
   integer seed = 32'ha84ce56a;
   always #5 core_clk = ~core_clk;
   osw_host i_host (.cs_n, .sclk, .sdi, .sdo);
   osw_top #(.FILT_CYC(FILT)) i_dut (.core_clk, .nrst, .clk_en(1'b1),
      .chip_select_n(cs_n), .serial_clock(sclk), .serial_input_pin(sdi),
      .serial_output(sdo), .serial_output_oe_n(oe_n), .device_wake(wake),
      .logic_supply_ok(sup), .direct_drive_five(dd5),
      .direct_drive_six(dd6), .supply_overvoltage_level(ov),
      .thermal_shutdown(therm), .short_detect(shrt),
      .open_load_threshold(olt), .switch_on(sw), .sense_enable(sen));
   function automatic osw_pkg::osw_chan_t olc();
      return olt & ~cmd[7:0] & cmd[15:8];
   endfunction
   function automatic osw_pkg::osw_chan_t esw();
      if (ov || !wake || !sup)
         return 8'h00;
      return (cmd[7:0] | {2'b00, dd6, dd5, 4'h0}) & ~therm;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step;
      repeat (40) @(negedge core_clk);
      ol_lat |= olc();
      chk({sen, sw, oe_n}, {cmd[15:8], esw(), 1'b1});
   endtask
   task automatic frame(input logic [31:0] tx, input int n);
      logic [31:0] rx;
      logic [15:0] st;
      st = {8'h00, shrt | therm | ol_lat};
      // Latch reloads from the live condition at the read
      ol_lat = olc();
      i_host.xfer(tx, n, rx);
      if (n >= 16 && n % 8 == 0)
      begin
         cmd = tx[15:0];
         chk(rx[n-1 -: 16], st);
      end
      if (n == 32)
         chk(rx[15:0], tx[31:16]);
      step;
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #200000;
      fail_count++;
      summarize;
   end
   initial
   begin
      repeat (16) @(negedge core_clk);
      nrst = 1'b1;
      step;
      repeat (6)
         frame($random(seed), 16);
      frame($random(seed), 15);
      frame($random(seed), 24);
      frame(32'h5a3c_0ff0, 32);
      ov = 1'b1;
      step;
      ov = 1'b0;
      step;
      therm = 8'h30;
      step;
      frame(32'h0010, 16);
      therm = 8'h00;
      step;
      shrt = 8'h81;
      frame(32'h0000, 16);
      shrt = 8'h00;
      {dd5, dd6} = 2'b11;
      step;
      {dd5, dd6} = 2'b00;
      frame(32'h0300, 16);
      olt = 8'h07;
      step;
      frame(32'h0302, 16);
      olt = 8'h00;
      step;
      frame(32'h0300, 16);
      for (int i = 0; i < 2; i++)
      begin
         frame(32'hff00, 16);
         {sup, wake} = i[0] ? 2'b01 : 2'b10;
         cmd = 0;
         ol_lat = '0;
         step;
         {sup, wake} = 2'b11;
         step;
      end
      summarize;
   end
endmodule
